// [hdl/swpc_consts.vh]
`ifndef SWPC_CONSTS_VH
`define SWPC_CONSTS_VH
// register byte offsets
`define SWPC_REG_CTRL 12'h000
`define SWPC_REG_STATUS 12'h004
`define SWPC_REG_WAKECFG 12'h008
`define SWPC_REG_RTC_LO 12'h00C
`define SWPC_REG_RTC_HI 12'h010
`define SWPC_REG_CMP_LO 12'h014
`define SWPC_REG_CMP_HI 12'h018
`define SWPC_REG_SLOWINC 12'h01C
`define SWPC_REG_SLEEPCFG 12'h020
`define SWPC_REG_MEM_BASE 12'h100
`define SWPC_REG_MEM_LAST 12'h17C
// ctrl fields
`define SWPC_CTRL_SLEEP 0
// wakecfg fields
`define SWPC_WK_PIN_EN 0
`define SWPC_WK_PIN_POL 1
`define SWPC_WK_RTC_EN 2
`define SWPC_WK_USB_EN 3
`define SWPC_WK_SLOW_EN 4
// sleepcfg fields
`define SWPC_SC_SUPPLY_LSB 0
`define SWPC_SC_PFM 4
`define SWPC_SC_CLKMASK 5
`define SWPC_SC_RESET 6
// reset values
`define SWPC_SLOWINC_RST 32'h00000140
`define SWPC_SLEEPCFG_RST 32'h0000000F
`define SWPC_WAKECFG_RST 32'h00000000
// timing
`define SWPC_CLK_HZ 10000000
`define SWPC_SLOW_HZ 31250
`define SWPC_SLOW_DIV (`SWPC_CLK_HZ / `SWPC_SLOW_HZ)
`define SWPC_STEP_NS 1000
`define SWPC_STEP_CYC ((`SWPC_STEP_NS * (`SWPC_CLK_HZ / 1000000) + 999) / 1000)
// state codes
`define SWPC_ST_AWAKE 3'h0
`define SWPC_ST_S_CLK 3'h1
`define SWPC_ST_S_RST 3'h2
`define SWPC_ST_S_PWR 3'h3
`define SWPC_ST_ASLEEP 3'h4
`define SWPC_ST_W_PWR 3'h5
`define SWPC_ST_W_RST 3'h6
`define SWPC_ST_W_CLK 3'h7
`endif

// [hdl/swpc_power_ctrl.v]
// Behaviour
// - quiescent and running states joined only through sequencing states
// - sleep begins on control register write or usb standby request
// - wake stimuli act only in the asleep state
// - wake seen during sleep entry is held and acted on when asleep
// - wake pin, software picks assertion or deassertion as trigger
// - wake when 64-bit counter reaches programmed compare value
// - usb host wakeup exits sleep when usb wake enabled
// - awake, counter adds one per main clock tick
// - asleep, counter may add programmable increment per slow tick
// - asleep powers down digital node, wake logic and counter stay on
// - 128 byte retention memory written before sleep, read after wake
// - power-good loss during either transition, outside the wake power-up step, issues full system reset
// - watchdog enabled and clocked only while awake
// - switched io supply on only while awake
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "swpc_consts.vh"
module swpc_power_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // wake and sleep sources
  input wire usb_standby_req,
  input wire usb_wake_req,
  input wire wake_pin,
  input wire [3:0] power_good,
  // power controls
  output reg digital_node_power_q,
  output reg clock_mask_q,
  output reg core_reset_q,
  output reg [3:0] supply_enable_q,
  output reg pulse_frequency_mode_q,
  output reg switched_io_supply_q,
  output reg watchdog_enable_q,
  output reg system_reset_q,
  output reg [2:0] power_state_q
);
  // decoded handshake
  reg [11:0] wr_addr_q;
  reg aw_held_q;
  reg [31:0] wr_data_q;
  reg [3:0] wr_strb_q;
  reg w_held_q;
  reg rd_pend_q;
  reg [11:0] rd_addr_q;
  // registers
  reg [31:0] wake_cfg_q;
  reg [63:0] rtc_q;
  reg [63:0] cmp_q;
  reg [31:0] slow_inc_q;
  reg [31:0] sleep_cfg_q;
  reg sleep_req_q;
  reg wake_pend_q;
  reg pin_prev_q;
  reg [15:0] slow_cnt_q;
  reg slow_tick_q;
  reg [7:0] step_cnt_q;
  reg [2:0] state_d;
  reg [31:0] rd_mux;
  wire [31:0] mem_rdata;
  wire wr_go;
  wire mem_wr_hit;
  wire asleep;
  wire pg_all;
  wire step_done;
  wire pin_edge;
  wire rtc_hit;
  wire wake_now;
  localparam [31:0] STEP_LOAD = `SWPC_STEP_CYC - 1, SLOW_LAST = `SWPC_SLOW_DIV - 1;

  function is_mem;
    input [11:0] a;
    begin
      is_mem = (a >= `SWPC_REG_MEM_BASE) && (a <= `SWPC_REG_MEM_LAST);
    end
  endfunction

  function is_reg;
    input [11:0] a;
    begin
      is_reg = is_mem(a) || (a <= `SWPC_REG_SLEEPCFG && a[1:0] == 2'h0);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[8*i +: 8] = nw[8*i +: 8];
        end
      end
    end
  endfunction

  // axi write channel capture, either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign mem_wr_hit = wr_go && is_mem(wr_addr_q);
  assign s_axi_arready = !rd_pend_q && !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      wr_addr_q <= 12'h000;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        wr_addr_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_reg(wr_addr_q) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // retention memory
  swpc_retention_mem u_mem (
    .aclk(aclk),
    .we(mem_wr_hit),
    .waddr(wr_addr_q[6:2]),
    .wdata(wr_data_q),
    .wstrb(wr_strb_q),
    .raddr((s_axi_arvalid && s_axi_arready) ? s_axi_araddr[6:2] : rd_addr_q[6:2]),
    .rdata_q(mem_rdata)
  );

  // read mux
  always @* begin
    case (rd_addr_q)
      `SWPC_REG_CTRL: rd_mux = {31'h0, sleep_req_q};
      `SWPC_REG_STATUS: rd_mux = {27'h0, wake_pend_q, pg_all, power_state_q};
      `SWPC_REG_WAKECFG: rd_mux = wake_cfg_q;
      `SWPC_REG_RTC_LO: rd_mux = rtc_q[31:0];
      `SWPC_REG_RTC_HI: rd_mux = rtc_q[63:32];
      `SWPC_REG_CMP_LO: rd_mux = cmp_q[31:0];
      `SWPC_REG_CMP_HI: rd_mux = cmp_q[63:32];
      `SWPC_REG_SLOWINC: rd_mux = slow_inc_q;
      `SWPC_REG_SLEEPCFG: rd_mux = sleep_cfg_q;
      default: rd_mux = is_mem(rd_addr_q) ? mem_rdata : 32'h00000000;
    endcase
  end

  // read channel: address cycle, memory cycle, answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= {s_axi_araddr[11:2], 2'h0};
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= is_reg(rd_addr_q) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sequencing helpers
  assign asleep = (power_state_q == `SWPC_ST_ASLEEP);
  assign pg_all = &(power_good | ~supply_enable_q);
  assign step_done = (step_cnt_q == 8'h00);
  assign pin_edge = wake_cfg_q[`SWPC_WK_PIN_POL] ? (pin_prev_q && !wake_pin)
                                                 : (!pin_prev_q && wake_pin);
  assign rtc_hit = wake_cfg_q[`SWPC_WK_RTC_EN] && (rtc_q >= cmp_q);
  assign wake_now = wake_pend_q || (wake_cfg_q[`SWPC_WK_PIN_EN] && pin_edge) || rtc_hit ||
                    (wake_cfg_q[`SWPC_WK_USB_EN] && usb_wake_req);

  // next state, fixed order each way
  always @* begin
    state_d = power_state_q;
    case (power_state_q)
      `SWPC_ST_AWAKE: if (sleep_req_q || usb_standby_req) state_d = `SWPC_ST_S_CLK;
      `SWPC_ST_S_CLK: if (step_done) state_d = `SWPC_ST_S_RST;
      `SWPC_ST_S_RST: if (step_done) state_d = `SWPC_ST_S_PWR;
      `SWPC_ST_S_PWR: if (step_done) state_d = `SWPC_ST_ASLEEP;
      `SWPC_ST_ASLEEP: if (wake_now) state_d = `SWPC_ST_W_PWR;
      `SWPC_ST_W_PWR: if (step_done && pg_all) state_d = `SWPC_ST_W_RST;
      `SWPC_ST_W_RST: if (step_done) state_d = `SWPC_ST_W_CLK;
      `SWPC_ST_W_CLK: if (step_done) state_d = `SWPC_ST_AWAKE;
      default: state_d = `SWPC_ST_AWAKE;
    endcase
  end

  // control registers and state
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_cfg_q <= `SWPC_WAKECFG_RST;
      cmp_q <= 64'hFFFFFFFFFFFFFFFF;
      slow_inc_q <= `SWPC_SLOWINC_RST;
      sleep_cfg_q <= `SWPC_SLEEPCFG_RST;
      sleep_req_q <= 1'b0;
      wake_pend_q <= 1'b0;
      pin_prev_q <= 1'b0;
      power_state_q <= `SWPC_ST_AWAKE;
      step_cnt_q <= 8'h00;
      system_reset_q <= 1'b0;
    end else begin
      pin_prev_q <= wake_pin;
      system_reset_q <= 1'b0;
      if (wr_go) begin
        case (wr_addr_q)
          `SWPC_REG_CTRL: if (power_state_q == `SWPC_ST_AWAKE && wr_strb_q[0])
            sleep_req_q <= wr_data_q[`SWPC_CTRL_SLEEP];
          `SWPC_REG_WAKECFG: wake_cfg_q <= merge(wake_cfg_q, wr_data_q, wr_strb_q);
          `SWPC_REG_CMP_LO: cmp_q[31:0] <= merge(cmp_q[31:0], wr_data_q, wr_strb_q);
          `SWPC_REG_CMP_HI: cmp_q[63:32] <= merge(cmp_q[63:32], wr_data_q, wr_strb_q);
          `SWPC_REG_SLOWINC: slow_inc_q <= merge(slow_inc_q, wr_data_q, wr_strb_q);
          `SWPC_REG_SLEEPCFG: sleep_cfg_q <= merge(sleep_cfg_q, wr_data_q, wr_strb_q);
          default: ;
        endcase
      end
      // pending wake gathered during sleep entry, power-good reset clear wins over set
      if (power_state_q >= `SWPC_ST_S_CLK && power_state_q <= `SWPC_ST_S_PWR) begin
        if ((wake_cfg_q[`SWPC_WK_PIN_EN] && pin_edge) || rtc_hit ||
            (wake_cfg_q[`SWPC_WK_USB_EN] && usb_wake_req)) begin
          wake_pend_q <= 1'b1;
        end
      end else if (power_state_q == `SWPC_ST_ASLEEP) begin
        wake_pend_q <= 1'b0;
      end
      if (power_state_q != state_d) begin
        step_cnt_q <= STEP_LOAD[7:0];
      end else if (!step_done) begin
        step_cnt_q <= step_cnt_q - 8'h01;
      end
      if (power_state_q != `SWPC_ST_AWAKE && power_state_q != `SWPC_ST_ASLEEP && !asleep &&
          !pg_all && power_state_q != `SWPC_ST_W_PWR) begin
        system_reset_q <= 1'b1;
        power_state_q <= `SWPC_ST_AWAKE;
        sleep_req_q <= 1'b0;
        wake_pend_q <= 1'b0;
      end else begin
        power_state_q <= state_d;
        if (power_state_q == `SWPC_ST_S_CLK) begin
          sleep_req_q <= 1'b0;
        end
      end
    end
  end

  // real-time counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      rtc_q <= 64'h0000000000000000;
      slow_cnt_q <= 16'h0000;
      slow_tick_q <= 1'b0;
    end else begin
      slow_tick_q <= 1'b0;
      if (slow_cnt_q == SLOW_LAST[15:0]) begin
        slow_cnt_q <= 16'h0000;
        slow_tick_q <= 1'b1;
      end else begin
        slow_cnt_q <= slow_cnt_q + 16'h0001;
      end
      if (wr_go && wr_addr_q == `SWPC_REG_RTC_LO) begin
        rtc_q[31:0] <= merge(rtc_q[31:0], wr_data_q, wr_strb_q);
      end else if (wr_go && wr_addr_q == `SWPC_REG_RTC_HI) begin
        rtc_q[63:32] <= merge(rtc_q[63:32], wr_data_q, wr_strb_q);
      end else if (asleep && wake_cfg_q[`SWPC_WK_SLOW_EN]) begin
        if (slow_tick_q) begin
          rtc_q <= rtc_q + {32'h0, slow_inc_q};
        end
      end else begin
        rtc_q <= rtc_q + 64'h1;
      end
    end
  end

  // power outputs per state
  always @(posedge aclk) begin
    if (!aresetn) begin
      digital_node_power_q <= 1'b1;
      clock_mask_q <= 1'b0;
      core_reset_q <= 1'b0;
      supply_enable_q <= 4'hF;
      pulse_frequency_mode_q <= 1'b0;
      switched_io_supply_q <= 1'b1;
      watchdog_enable_q <= 1'b1;
    end else begin
      switched_io_supply_q <= (state_d == `SWPC_ST_AWAKE);
      watchdog_enable_q <= (state_d == `SWPC_ST_AWAKE);
      case (state_d)
        `SWPC_ST_S_CLK, `SWPC_ST_W_CLK: begin
          clock_mask_q <= sleep_cfg_q[`SWPC_SC_CLKMASK];
          core_reset_q <= 1'b0;
        end
        `SWPC_ST_S_RST, `SWPC_ST_W_RST: begin
          clock_mask_q <= sleep_cfg_q[`SWPC_SC_CLKMASK];
          core_reset_q <= sleep_cfg_q[`SWPC_SC_RESET];
          digital_node_power_q <= 1'b1;
          supply_enable_q <= 4'hF;
          pulse_frequency_mode_q <= 1'b0;
        end
        `SWPC_ST_S_PWR, `SWPC_ST_ASLEEP: begin
          digital_node_power_q <= 1'b0;
          supply_enable_q <= sleep_cfg_q[`SWPC_SC_SUPPLY_LSB +: 4];
          pulse_frequency_mode_q <= sleep_cfg_q[`SWPC_SC_PFM];
        end
        `SWPC_ST_W_PWR: begin
          digital_node_power_q <= 1'b1;
          supply_enable_q <= 4'hF;
          pulse_frequency_mode_q <= 1'b0;
        end
        default: begin
          digital_node_power_q <= 1'b1;
          clock_mask_q <= 1'b0;
          core_reset_q <= 1'b0;
          supply_enable_q <= 4'hF;
          pulse_frequency_mode_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // swpc_power_ctrl
`default_nettype wire

// [hdl/swpc_retention_mem.v]
`timescale 1ns/1ps
`default_nettype none
module swpc_retention_mem (
  // clock
  input wire aclk,
  // write port
  input wire we,
  input wire [4:0] waddr,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // read port
  input wire [4:0] raddr,
  output reg [31:0] rdata_q
);
  wire [31:0] rd_word;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      reg [7:0] mem [0:31];
      always @(posedge aclk) begin
        if (we && wstrb[g]) begin
          mem[waddr] <= wdata[8*g+7:8*g];
        end
      end
      assign rd_word[8*g+7:8*g] = mem[raddr];
    end
  endgenerate
  always @(posedge aclk) begin
    rdata_q <= rd_word;
  end
endmodule // swpc_retention_mem
`default_nettype wire

// [testbench/swpc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module swpc_assertions (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // watched ports
  input wire usb_standby_req,
  input wire digital_node_power_q,
  input wire switched_io_supply_q,
  input wire watchdog_enable_q,
  input wire system_reset_q,
  input wire [2:0] power_state_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire asleep = power_state_q == 3'h4;
  a_io_off_asleep: assert property (asleep |-> !switched_io_supply_q)
    else $error("io supply on while asleep");
  a_wdog_off_asleep: assert property (asleep |-> !watchdog_enable_q)
    else $error("watchdog on while asleep");
  a_node_off_asleep: assert property (asleep |-> !digital_node_power_q)
    else $error("digital node powered while asleep");
  a_state_order: assert property ($changed(power_state_q) |->
    power_state_q == $past(power_state_q) + 3'h1 || power_state_q == 3'h0)
    else $error("state left its fixed order");
  a_step_length: assert property ((power_state_q == 3'h1 && $past(power_state_q) == 3'h0)
    |-> ##9 power_state_q inside {3'h0, 3'h1})
    else $error("clock step shorter than ten cycles");
  a_usb_sleep_start: assert property (power_state_q == 3'h0 && usb_standby_req
    |=> power_state_q == 3'h1)
    else $error("usb standby request ignored");
  a_sreset_pulse: assert property (system_reset_q |=> !system_reset_q)
    else $error("system reset longer than one cycle");
  a_sreset_awake: assert property ($rose(system_reset_q) |-> ##[0:1] power_state_q == 3'h0)
    else $error("system reset without return to awake");
  c_asleep: cover property (asleep);
  c_wake_end: cover property (power_state_q == 3'h7);
  c_sreset: cover property (system_reset_q);
endmodule // swpc_assertions
bind swpc_power_ctrl swpc_assertions swpc_assertions_inst (.aclk, .aresetn, .usb_standby_req,
  .digital_node_power_q, .switched_io_supply_q, .watchdog_enable_q, .system_reset_q,
  .power_state_q);
`default_nettype wire

// [testbench/swpc_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module swpc_partner (
  // clock and state
  input wire aclk,
  input wire [2:0] power_state_q,
  // usb block, pin and supplies
  output logic usb_standby_req,
  output logic usb_wake_req,
  output logic wake_pin,
  output logic [3:0] power_good
);
  initial begin
    usb_standby_req = 1'b0;
    usb_wake_req = 1'b0;
    wake_pin = 1'b0;
    power_good = 4'hF;
  end
  // one-cycle request, made only while awake
  task automatic usb_sleep();
    @(posedge aclk);
    if (power_state_q == 3'h0) begin
      usb_standby_req <= 1'b1;
      @(posedge aclk);
      usb_standby_req <= 1'b0;
    end
  endtask
  task automatic usb_wake();
    @(posedge aclk);
    usb_wake_req <= 1'b1;
    @(posedge aclk);
    usb_wake_req <= 1'b0;
  endtask
  task automatic pin(input logic v);
    @(posedge aclk);
    wake_pin <= v;
  endtask
  task automatic pg(input logic [3:0] v);
    @(posedge aclk);
    power_good <= v;
  endtask
endmodule // swpc_partner
`default_nettype wire

// [testbench/swpc_power_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swpc_consts.vh"
module swpc_power_ctrl_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d, d2;
  logic [3:0] s_axi_wstrb;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire usb_standby_req, usb_wake_req, wake_pin, digital_node_power_q, clock_mask_q;
  wire core_reset_q, pulse_frequency_mode_q, switched_io_supply_q, watchdog_enable_q;
  wire system_reset_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] power_good, supply_enable_q;
  wire [2:0] power_state_q;
  int n_errors = 0;
  int samples_checked = 0;
  swpc_power_ctrl swpc_power_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .usb_standby_req(usb_standby_req), .usb_wake_req(usb_wake_req), .wake_pin(wake_pin),
    .power_good(power_good),
    .digital_node_power_q(digital_node_power_q), .clock_mask_q(clock_mask_q),
    .core_reset_q(core_reset_q), .supply_enable_q(supply_enable_q),
    .pulse_frequency_mode_q(pulse_frequency_mode_q),
    .switched_io_supply_q(switched_io_supply_q), .watchdog_enable_q(watchdog_enable_q),
    .system_reset_q(system_reset_q), .power_state_q(power_state_q)
  );
  swpc_partner swpc_partner_inst (
    .aclk(aclk), .power_state_q(power_state_q), .usb_standby_req(usb_standby_req),
    .usb_wake_req(usb_wake_req), .wake_pin(wake_pin), .power_good(power_good)
  );
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrs(input logic [11:0] a, input logic [31:0] v, input logic [3:0] st);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    wrs(a, v, 4'hF);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, 32'h0);
  endtask
  task automatic wait_st(input logic [2:0] s, input int n);
    for (int i = 0; i < n && power_state_q !== s; i++) @(posedge aclk);
    chk({29'h0, power_state_q}, {29'h0, s});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk({28'h0, digital_node_power_q, switched_io_supply_q, watchdog_enable_q,
      system_reset_q}, 32'h0000000E);
    rc(`SWPC_REG_SLOWINC, `SWPC_SLOWINC_RST);
    rc(`SWPC_REG_SLEEPCFG, `SWPC_SLEEPCFG_RST);
    rc(`SWPC_REG_WAKECFG, `SWPC_WAKECFG_RST);
    rd(12'hE40, d, r);
    chk({30'h0, r}, 32'h00000002);
    rd(`SWPC_REG_RTC_LO, d, r);
    rd(`SWPC_REG_RTC_LO, d2, r);
    chk(d2 - d, 32'h00000004);
    wr(`SWPC_REG_MEM_BASE, 32'hA5A50001);
    wr(`SWPC_REG_MEM_LAST, 32'h5A5A0002);
    chk({30'h0, r}, 32'h00000000);
    wrs(`SWPC_REG_MEM_BASE + 12'h004, 32'h11223344, 4'hF);
    wrs(`SWPC_REG_MEM_BASE + 12'h004, 32'hAABBCCDD, 4'h5);
    wrs(12'hFFC, 32'h00000000, 4'hA);
    chk({30'h0, r}, 32'h00000002);
    wr(`SWPC_REG_SLEEPCFG, 32'h00000072);
    wr(`SWPC_REG_WAKECFG, 32'h00000001);
    swpc_partner_inst.pin(1'b1);
    repeat (5) @(posedge aclk);
    chk({29'h0, power_state_q}, 32'h0);
    swpc_partner_inst.pin(1'b0);
    wr(`SWPC_REG_CTRL, 32'h00000001);
    wait_st(3'h4, 80);
    chk({28'h0, digital_node_power_q, switched_io_supply_q, watchdog_enable_q,
      system_reset_q}, 32'h0);
    chk({25'h0, supply_enable_q, pulse_frequency_mode_q, clock_mask_q, core_reset_q},
      32'h00000017);
    rc(`SWPC_REG_STATUS, 32'h0000000C);
    swpc_partner_inst.pin(1'b1);
    wait_st(3'h0, 100);
    rc(`SWPC_REG_MEM_BASE, 32'hA5A50001);
    rc(`SWPC_REG_MEM_LAST, 32'h5A5A0002);
    rc(`SWPC_REG_MEM_BASE + 12'h004, 32'h11BB33DD);
    swpc_partner_inst.pin(1'b0);
    wr(`SWPC_REG_CTRL, 32'h00000001);
    wait_st(3'h1, 5);
    swpc_partner_inst.pin(1'b1);
    wait_st(3'h4, 80);
    wait_st(3'h0, 100);
    wr(`SWPC_REG_WAKECFG, 32'h00000008);
    swpc_partner_inst.usb_sleep();
    wait_st(3'h4, 80);
    swpc_partner_inst.usb_wake();
    wait_st(3'h0, 100);
    wr(`SWPC_REG_RTC_HI, 32'h0);
    wr(`SWPC_REG_RTC_LO, 32'h0);
    wr(`SWPC_REG_SLOWINC, 32'h00001000);
    wr(`SWPC_REG_CMP_LO, 32'h00000800);
    wr(`SWPC_REG_CMP_HI, 32'h0);
    wr(`SWPC_REG_WAKECFG, 32'h00000014);
    wr(`SWPC_REG_CTRL, 32'h00000001);
    wait_st(3'h4, 80);
    wait_st(3'h0, 1200);
    wr(`SWPC_REG_WAKECFG, 32'h0);
    wr(`SWPC_REG_CTRL, 32'h00000001);
    wait_st(3'h1, 5);
    swpc_partner_inst.pg(4'h0);
    wait_st(3'h0, 5);
    swpc_partner_inst.pg(4'hF);
    wrap_up();
  end
endmodule // swpc_power_ctrl_tb_top
`default_nettype wire
